// File: rtl/capture_compare_and_reload_timers.sv
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module capture_compare_and_reload_timers
    import timer_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    // Avalon-MM slave
    input  wire logic [7:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [3:0]  byteenable_i,
    input  wire logic [31:0] writedata_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    // Timer pins
    input  wire logic        capture_in_pin_i,
    output logic             compare_out_pin_o,
    // Interrupt requests
    output logic             free_timer_irq_o,
    output logic             reload_timer_irq_o
);

    // ==========================================================
    // State
    typedef struct packed {
        // Bus answer
        logic         ack;
        logic [7:0]   rdata;
        // Free-running timer
        timer_state_e phase;
        logic [15:0]  cnt;
        logic [15:0]  cap;
        logic [15:0]  cmp;
        logic         inhibit;
        logic [2:0]   irq_en;
        logic         edge_sel;
        logic [2:0]   flags;
        logic [2:0]   armed;
        // Edge and match pipeline
        logic         cap_prev;
        logic         cap_pend;
        logic         cmp_pend;
        logic         cap_lock;
        logic         cmp_lock;
        logic         pin;
        // Reload timer
        logic         rl_en;
        logic         rl_irq_en;
        logic [1:0]   rl_sel;
        logic         rl_uf;
        logic [4:0]   rl_pre;
        logic [15:0]  rl_cnt;
        logic [15:0]  rl_preset;
    } state_s;

    localparam state_s STATE_RST = '{
        // Bus answer
        ack:       1'b0,
        rdata:     8'h00,
        // Free-running timer
        phase:     ST_IDLE,
        cnt:       FREE_CNT_RST,
        cap:       16'h0000,
        cmp:       COMPARE_RST,
        inhibit:   1'b0,
        irq_en:    3'h0,
        edge_sel:  1'b0,
        flags:     3'h0,
        armed:     3'h0,
        // Edge and match pipeline
        cap_prev:  1'b0,
        cap_pend:  1'b0,
        cmp_pend:  1'b0,
        cap_lock:  1'b0,
        cmp_lock:  1'b0,
        pin:       1'b0,
        // Reload timer
        rl_en:     1'b0,
        rl_irq_en: 1'b0,
        rl_sel:    2'h0,
        rl_uf:     1'b0,
        rl_pre:    5'h00,
        rl_cnt:    RELOAD_RST,
        rl_preset: RELOAD_RST
    };

    state_s q;
    state_s d;
    logic [2:0] flag_irq;
    // Output level bit sits outside the reset state
    logic   out_level_q;
    logic   out_level_d;

    // ==========================================================
    // Prescaler terminal count for the reload timer
    function automatic logic [4:0] div_last(input logic [1:0] sel);
        logic [4:0] r;
        case (sel)
            2'h0:    r = RL_DIV_LAST_4;
            2'h1:    r = RL_DIV_LAST_8;
            2'h2:    r = RL_DIV_LAST_16;
            default: r = RL_DIV_LAST_32;
        endcase
        return r;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        logic [5:0] idx;
        logic [7:0] wd;
        logic [7:0] rb;
        logic       rd_done;
        logic       wr_done;
        logic       cap_edge;
        logic       load;
        // Register index from the byte address
        idx      = address_i[7:2];
        wd       = writedata_i[7:0];
        rb       = 8'h00;
        d        = q;
        out_level_d = out_level_q;
        // Accesses complete in the answering cycle
        rd_done  = q.ack & read_i;
        wr_done  = q.ack & write_i & byteenable_i[0];
        // Load marks a restart of the reload timer
        load     = 1'b0;
        cap_edge = 1'b0;

        // Bus handshake: one wait cycle, then answer
        d.ack = (read_i | write_i) & ~q.ack;

        case (idx)
            IDX_EVENT_GATE:    rb = {q.inhibit, 7'h00};
            IDX_TIMER_CONTROL: rb = {q.irq_en, 3'h0, q.edge_sel, out_level_q};
            IDX_TIMER_FLAGS:   rb = {q.flags, 5'h00};
            IDX_CAPTURE_HI:    rb = q.cap[15:8];
            IDX_CAPTURE_LO:    rb = q.cap[7:0];
            IDX_COMPARE_HI:    rb = q.cmp[15:8];
            IDX_COMPARE_LO:    rb = q.cmp[7:0];
            IDX_COUNTER_HI:    rb = q.cnt[15:8];
            IDX_COUNTER_LO:    rb = q.cnt[7:0];
            // Alternate counter: same value, no side effect
            IDX_ALT_COUNT_HI:  rb = q.cnt[15:8];
            IDX_ALT_COUNT_LO:  rb = q.cnt[7:0];
            IDX_RELOAD_CTRL:   rb = {q.rl_en, q.rl_irq_en, 3'h0, q.rl_sel, q.rl_uf};
            IDX_PRESET_HI:     rb = q.rl_preset[15:8];
            IDX_PRESET_LO:     rb = q.rl_preset[7:0];
            IDX_RL_COUNT_HI:   rb = q.rl_cnt[15:8];
            IDX_RL_COUNT_LO:   rb = q.rl_cnt[7:0];
            IDX_RL_ALT_HI:     rb = q.rl_cnt[15:8];
            IDX_RL_ALT_LO:     rb = q.rl_cnt[7:0];
            default:           rb = 8'h00;
        endcase
        // Read data is latched in the wait cycle
        if (read_i & ~q.ack) begin
            d.rdata = rb;
        end

        // ======================================================
        // Read side effects
        if (rd_done) begin
            case (idx)
                // Status read arms only the flags now set
                IDX_TIMER_FLAGS: d.armed = q.flags;
                // High byte read freezes capture until low byte
                IDX_CAPTURE_HI:  d.cap_lock = 1'b1;
                IDX_CAPTURE_LO: begin
                    d.cap_lock = 1'b0;
                    if (q.armed[FL_CAP]) begin
                        d.flags[FL_CAP] = 1'b0;
                        d.armed[FL_CAP] = 1'b0;
                    end
                end
                IDX_COMPARE_LO: begin
                    if (q.armed[FL_CMP]) begin
                        d.flags[FL_CMP] = 1'b0;
                        d.armed[FL_CMP] = 1'b0;
                    end
                end
                IDX_COUNTER_LO: begin
                    if (q.armed[FL_OVF]) begin
                        d.flags[FL_OVF] = 1'b0;
                        d.armed[FL_OVF] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // ======================================================
        // Register writes
        if (wr_done) begin
            case (idx)
                IDX_EVENT_GATE:    d.inhibit = wd[BIT_INHIBIT];
                IDX_TIMER_CONTROL: begin
                    d.irq_en      = wd[BIT_CAP_IRQ_EN:BIT_OVF_IRQ_EN];
                    d.edge_sel    = wd[BIT_EDGE_SEL];
                    out_level_d   = wd[BIT_OUT_LEVEL];
                end
                // High byte write holds off matches until low byte
                IDX_COMPARE_HI: begin
                    d.cmp[15:8] = wd;
                    d.cmp_lock  = 1'b1;
                end
                IDX_COMPARE_LO: begin
                    d.cmp[7:0]  = wd;
                    d.cmp_lock  = 1'b0;
                end
                IDX_RELOAD_CTRL: begin
                    d.rl_en     = wd[BIT_RL_EN];
                    d.rl_irq_en = wd[BIT_UF_IRQ_EN];
                    d.rl_sel    = {wd[BIT_RL_SEL1], wd[BIT_RL_SEL0]};
                    // Writing zero clears the underflow flag, one keeps it
                    if (!wd[BIT_UF_FLAG]) begin
                        d.rl_uf = 1'b0;
                    end
                    // Enable rising edge restarts from the preset
                    if (wd[BIT_RL_EN] && !q.rl_en) begin
                        load     = 1'b1;
                        d.rl_cnt = q.rl_preset;
                        d.rl_pre = 5'h00;
                    end
                end
                IDX_PRESET_HI: d.rl_preset[15:8] = wd;
                IDX_PRESET_LO: d.rl_preset[7:0]  = wd;
                default: begin
                end
            endcase
        end

        // ======================================================
        // Free-running timer state sequence
        // Four phases per count; counter moves once a lap
        case (q.phase)
            ST_IDLE:           d.phase = ST_COMPARE;
            ST_COMPARE:        d.phase = ST_CAPTURE_WINDOW;
            ST_CAPTURE_WINDOW: d.phase = ST_FLAG_SET;
            ST_FLAG_SET:       d.phase = ST_IDLE;
            default:           d.phase = ST_IDLE;
        endcase

        case (q.phase)
            ST_COMPARE: begin
                // Match noted here, flagged in the flag phase
                if (q.cmp == q.cnt && !q.cmp_lock) begin
                    d.cmp_pend = 1'b1;
                end
            end
            ST_FLAG_SET: begin
                // Sets follow the clears above, so a set wins
                if (q.cmp_pend) begin
                    d.cmp_pend      = 1'b0;
                    d.flags[FL_CMP] = 1'b1;
                    d.pin           = out_level_q;
                end
                // Capture edge seen since the last flag phase
                if (q.cap_pend) begin
                    d.cap_pend      = 1'b0;
                    d.flags[FL_CAP] = 1'b1;
                end
                // Inhibit freezes counter and overflow together
                if (!q.inhibit) begin
                    d.cnt = q.cnt + 16'h0001;
                    if (q.cnt == FREE_CNT_MAX) begin
                        d.flags[FL_OVF] = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase

        // Capture edge detector
        // Previous pin level, compared every clock
        d.cap_prev = capture_in_pin_i;
        if (q.edge_sel) begin
            cap_edge = capture_in_pin_i & ~q.cap_prev;
        end else begin
            cap_edge = ~capture_in_pin_i & q.cap_prev;
        end
        if (cap_edge) begin
            d.cap_pend = 1'b1;
            // Copy blocked while the high byte is held
            if (!q.cap_lock) begin
                d.cap = q.cnt;
            end
        end

        // ======================================================
        // Reloadable down-counter
        // Disabled timer holds count and prescaler
        if (q.rl_en && !load) begin
            if (q.rl_pre == div_last(q.rl_sel)) begin
                d.rl_pre = 5'h00;
                // Count one reloads at once: zero is shown only with a zero preset
                if (q.rl_cnt == RELOAD_LAST) begin
                    d.rl_uf  = 1'b1;
                    d.rl_cnt = q.rl_preset;
                end else begin
                    d.rl_cnt = q.rl_cnt - 16'h0001;
                end
            end else begin
                // Prescaler counts up to the selected last value
                d.rl_pre = q.rl_pre + 5'h01;
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Output level bit is not part of this state
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // Output level bit keeps its value through reset
    always_ff @(posedge ref_clk_i) begin
        out_level_q <= out_level_d;
    end

    // ==========================================================
    // Per-flag free timer requests
    for (genvar g = 0; g < 3; g++) begin : g_flag_irq
        assign flag_irq[g] = q.flags[g] & q.irq_en[g];
    end

    // ==========================================================
    // Outputs
    // Read data: one byte, upper lanes zero
    assign readdata_o        = {24'h000000, q.rdata};
    // One wait cycle for every access
    assign waitrequest_o     = (read_i | write_i) & ~q.ack;
    // Pin is low from reset until a compare drives it
    assign compare_out_pin_o = q.pin;
    assign free_timer_irq_o  = |flag_irq;
    assign reload_timer_irq_o = q.rl_uf & q.rl_irq_en;

endmodule

// File: rtl/timer_pkg.sv
package timer_pkg;

    // ==========================================================
    // Register indices (byte address = 4 * index)
    localparam logic [5:0] IDX_EVENT_GATE    = 6'h16;
    localparam logic [5:0] IDX_TIMER_CONTROL = 6'h18;
    localparam logic [5:0] IDX_TIMER_FLAGS   = 6'h19;
    localparam logic [5:0] IDX_CAPTURE_HI    = 6'h1A;
    localparam logic [5:0] IDX_CAPTURE_LO    = 6'h1B;
    localparam logic [5:0] IDX_COMPARE_HI    = 6'h1C;
    localparam logic [5:0] IDX_COMPARE_LO    = 6'h1D;
    localparam logic [5:0] IDX_COUNTER_HI    = 6'h1E;
    localparam logic [5:0] IDX_COUNTER_LO    = 6'h1F;
    localparam logic [5:0] IDX_ALT_COUNT_HI  = 6'h20;
    localparam logic [5:0] IDX_ALT_COUNT_LO  = 6'h21;
    localparam logic [5:0] IDX_RELOAD_CTRL   = 6'h22;
    localparam logic [5:0] IDX_PRESET_HI     = 6'h23;
    localparam logic [5:0] IDX_PRESET_LO     = 6'h24;
    localparam logic [5:0] IDX_RL_COUNT_HI   = 6'h25;
    localparam logic [5:0] IDX_RL_COUNT_LO   = 6'h26;
    localparam logic [5:0] IDX_RL_ALT_HI     = 6'h27;
    localparam logic [5:0] IDX_RL_ALT_LO     = 6'h28;

    // ==========================================================
    // Field positions
    localparam int BIT_INHIBIT      = 7;
    localparam int BIT_CAP_IRQ_EN   = 7;
    localparam int BIT_CMP_IRQ_EN   = 6;
    localparam int BIT_OVF_IRQ_EN   = 5;
    localparam int BIT_EDGE_SEL     = 1;
    localparam int BIT_OUT_LEVEL    = 0;
    localparam int BIT_CAP_FLAG     = 7;
    localparam int BIT_CMP_FLAG     = 6;
    localparam int BIT_OVF_FLAG     = 5;
    localparam int BIT_RL_EN        = 7;
    localparam int BIT_UF_IRQ_EN    = 6;
    localparam int BIT_RL_SEL1      = 2;
    localparam int BIT_RL_SEL0      = 1;
    localparam int BIT_UF_FLAG      = 0;

    // Flag vector positions inside the state
    localparam int FL_CAP = 2;
    localparam int FL_CMP = 1;
    localparam int FL_OVF = 0;

    // ==========================================================
    // Reset values and counts
    localparam logic [15:0] FREE_CNT_RST   = 16'hFFFC;
    localparam logic [15:0] FREE_CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] RELOAD_RST     = 16'hFFFF;
    localparam logic [15:0] RELOAD_LAST    = 16'h0001;
    localparam logic [15:0] COMPARE_RST    = 16'h0000;
    localparam logic [4:0]  RL_DIV_LAST_4  = 5'h03;
    localparam logic [4:0]  RL_DIV_LAST_8  = 5'h07;
    localparam logic [4:0]  RL_DIV_LAST_16 = 5'h0F;
    localparam logic [4:0]  RL_DIV_LAST_32 = 5'h1F;

    // Timer state sequence, one state per bus clock
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COMPARE,
        ST_CAPTURE_WINDOW,
        ST_FLAG_SET
    } timer_state_e;

endpackage

// File: testbench/cc_timers_asserts.sv
`timescale 1ns/1ps
// ==========
// Port checker
module cc_timers_asserts
    import timer_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic [7:0]  address_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [3:0]  byteenable_i,
    input wire logic [31:0] writedata_i,
    input wire logic [31:0] readdata_o,
    input wire logic        waitrequest_o,
    input wire logic        capture_in_pin_i,
    input wire logic        compare_out_pin_o,
    input wire logic        free_timer_irq_o,
    input wire logic        reload_timer_irq_o
);
    logic [1:0] ph_q;
    logic       acc_w;
    logic [5:0] idx_w;
    assign acc_w = (read_i | write_i) & ~waitrequest_o;
    assign idx_w = address_i[7:2];
    // Timer phase, zero in the cycle after a flag-set edge
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ph_q <= 2'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
        end
    end
    default clocking dc @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    pin_reset_low_a: assert property (disable iff (1'b0)
        !reset_n_i |-> !compare_out_pin_o) else $error("compare pin high in reset");
    irq_reset_low_a: assert property (disable iff (1'b0)
        !reset_n_i |-> !free_timer_irq_o && !reload_timer_irq_o) else $error("irq in reset");
    ctrl_spare_zero_a: assert property (
        acc_w && read_i && idx_w == IDX_TIMER_CONTROL |-> readdata_o[4:2] == 3'h0)
        else $error("control spare bits not zero");
    irq_fall_cause_a: assert property (
        $fell(free_timer_irq_o) |-> $past(acc_w)) else $error("irq dropped without access");
    rl_fall_cause_a: assert property (
        $fell(reload_timer_irq_o) |-> $past(acc_w && write_i && idx_w == IDX_RELOAD_CTRL))
        else $error("reload irq dropped without write");
    irq_rise_phase_a: assert property (
        $rose(free_timer_irq_o) |-> ph_q == 2'h0 || $past(acc_w && write_i))
        else $error("irq rose off flag phase");
    pin_phase_a: assert property (
        $changed(compare_out_pin_o) |-> ph_q == 2'h0) else $error("pin moved off flag phase");
    wait_one_a: assert property (
        (read_i || write_i) && waitrequest_o |=> !waitrequest_o) else $error("wait too long");
endmodule

bind capture_compare_and_reload_timers cc_timers_asserts cc_timers_asserts_i (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i),
    .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .capture_in_pin_i(capture_in_pin_i), .compare_out_pin_o(compare_out_pin_o),
    .free_timer_irq_o(free_timer_irq_o), .reload_timer_irq_o(reload_timer_irq_o));

// File: testbench/capture_compare_and_reload_timers_test.sv
`timescale 1ns/1ps
module capture_compare_and_reload_timers_test import timer_pkg::*;;
    logic        ref_clk_i = 1'b0;
    logic        reset_n_i = 1'b1;
    logic [7:0]  address_i = 8'h00;
    logic        read_i = 1'b0;
    logic        write_i = 1'b0;
    logic [3:0]  byteenable_i = 4'h0;
    logic [31:0] writedata_i = 32'h0;
    logic        capture_in_pin_i = 1'b0;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    logic        compare_out_pin_o;
    logic        free_timer_irq_o;
    logic        reload_timer_irq_o;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          t1;
    logic [15:0] v;
    logic [7:0]  r;

    always #4 ref_clk_i = ~ref_clk_i;

    capture_compare_and_reload_timers capture_compare_and_reload_timers_i (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i),
        .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .capture_in_pin_i(capture_in_pin_i), .compare_out_pin_o(compare_out_pin_o),
        .free_timer_irq_o(free_timer_irq_o), .reload_timer_irq_o(reload_timer_irq_o));

    // ==========
    // Verdict and helpers
    task automatic close_out;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [5:0] i, input logic w, input logic [7:0] d,
                       input logic [3:0] be);
        address_i <= {i, 2'b00};
        read_i <= ~w;
        write_i <= w;
        writedata_i <= {24'h0, d};
        byteenable_i <= be;
        do @(posedge ref_clk_i); while (waitrequest_o !== 1'b0);
        r = readdata_o[7:0];
        read_i <= 1'b0;
        write_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        bus(i, 1'b1, d, 4'h1);
    endtask
    task automatic rd(input logic [5:0] i);
        bus(i, 1'b0, 8'h00, 4'h0);
    endtask
    task automatic rc(input logic [5:0] i, input logic [7:0] m, input logic [7:0] e);
        rd(i);
        chk({8'h00, r & m}, {8'h00, e});
    endtask
    task automatic irq_is(input logic s, input logic e);
        chk({15'h0, s ? reload_timer_irq_o : free_timer_irq_o}, {15'h0, e});
    endtask
    task automatic wait_irq(input logic s, input int lim);
        int k;
        k = 0;
        while ((s ? reload_timer_irq_o : free_timer_irq_o) !== 1'b1 && k < lim) begin
            @(posedge ref_clk_i);
            k++;
        end
        chk({15'h0, k < lim}, 16'h1);
    endtask

    // ==========
    // Scenarios
    task automatic t_reset;
        rc(IDX_COUNTER_HI, 8'hFF, 8'hFF);
        rc(IDX_TIMER_CONTROL, 8'hFE, 8'h00);
        wr(IDX_TIMER_CONTROL, 8'h00);
        chk({15'h0, compare_out_pin_o}, 16'h0);
        bus(IDX_EVENT_GATE, 1'b1, 8'h80, 4'h0);
        rc(IDX_EVENT_GATE, 8'hFF, 8'h00);
        rc(IDX_RELOAD_CTRL, 8'hFF, 8'h00);
        rc(IDX_PRESET_HI, 8'hFF, 8'hFF);
        rc(IDX_RL_COUNT_LO, 8'hFF, 8'hFF);
    endtask
    task automatic t_overflow;
        rc(IDX_TIMER_FLAGS, 8'h3F, 8'h20);
        wr(IDX_TIMER_CONTROL, 8'h20);
        irq_is(1'b0, 1'b1);
        rd(IDX_ALT_COUNT_LO);
        irq_is(1'b0, 1'b1);
        rd(IDX_COUNTER_LO);
        irq_is(1'b0, 1'b0);
    endtask
    task automatic t_inhibit;
        wr(IDX_EVENT_GATE, 8'h80);
        rd(IDX_ALT_COUNT_LO);
        v[7:0] = r;
        repeat (20) @(posedge ref_clk_i);
        rc(IDX_ALT_COUNT_LO, 8'hFF, v[7:0]);
    endtask
    task automatic t_compare(input logic lvl);
        rd(IDX_ALT_COUNT_HI);
        v[15:8] = r;
        rd(IDX_ALT_COUNT_LO);
        v[7:0] = r;
        v = v + 16'h2;
        wr(IDX_COMPARE_HI, v[15:8]);
        wr(IDX_COMPARE_LO, v[7:0]);
        rd(IDX_TIMER_FLAGS);
        rd(IDX_COMPARE_LO);
        wr(IDX_TIMER_CONTROL, {7'h20, lvl});
        rc(IDX_TIMER_CONTROL, 8'hFF, {7'h20, lvl});
        irq_is(1'b0, 1'b0);
        wr(IDX_EVENT_GATE, 8'h00);
        wait_irq(1'b0, 40);
        chk({15'h0, compare_out_pin_o}, {15'h0, lvl});
        rc(IDX_TIMER_FLAGS, 8'h40, 8'h40);
        rd(IDX_COMPARE_LO);
        irq_is(1'b0, 1'b0);
        wr(IDX_EVENT_GATE, 8'h80);
    endtask
    task automatic t_capture(input logic sel);
        wr(IDX_TIMER_CONTROL, {6'h20, sel, 1'b0});
        capture_in_pin_i <= ~sel;
        repeat (8) @(posedge ref_clk_i);
        irq_is(1'b0, 1'b0);
        rd(IDX_ALT_COUNT_HI);
        v[15:8] = r;
        rd(IDX_ALT_COUNT_LO);
        v[7:0] = r;
        capture_in_pin_i <= sel;
        wait_irq(1'b0, 20);
        rc(IDX_CAPTURE_HI, 8'hFF, v[15:8]);
        rc(IDX_CAPTURE_LO, 8'hFF, v[7:0]);
        rd(IDX_TIMER_FLAGS);
        irq_is(1'b0, 1'b1);
        rd(IDX_CAPTURE_LO);
        irq_is(1'b0, 1'b0);
    endtask
    task automatic t_reload(input logic [1:0] sel);
        wr(IDX_PRESET_HI, 8'h00);
        wr(IDX_PRESET_LO, 8'h03);
        wr(IDX_RELOAD_CTRL, {5'h18, sel, 1'b0});
        wait_irq(1'b1, 400);
        t1 = cyc;
        wr(IDX_RELOAD_CTRL, {5'h18, sel, 1'b0});
        irq_is(1'b1, 1'b0);
        wait_irq(1'b1, 400);
        chk(16'(cyc - t1), 16'(3 * (4 << sel)));
        wr(IDX_RELOAD_CTRL, 8'h00);
        rd(IDX_RL_COUNT_LO);
        v[7:0] = r;
        repeat (40) @(posedge ref_clk_i);
        rc(IDX_RL_ALT_LO, 8'hFF, v[7:0]);
    endtask
    task automatic t_load;
        wr(IDX_PRESET_LO, 8'h55);
        wr(IDX_RELOAD_CTRL, 8'h86);
        rc(IDX_RL_COUNT_LO, 8'hFF, 8'h55);
        rc(IDX_RL_COUNT_HI, 8'hFF, 8'h00);
        wr(IDX_RELOAD_CTRL, 8'h00);
    endtask

    initial begin
        reset_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        t_reset();
        t_overflow();
        t_inhibit();
        t_compare(1'b1);
        t_compare(1'b0);
        t_capture(1'b0);
        t_capture(1'b1);
        for (int s = 0; s < 4; s++) begin
            t_reload(2'(s));
        end
        t_load();
        close_out();
    end
endmodule
